/* sfd_pkg.sv */
// Shared constants and types of the sinc and averaging decimation filter
package sfd_pkg;

	// ==========================================================
	// Filter kinds
	// ==========================================================
	typedef enum logic [1:0] {
		KIND_SINC5_AVG = 2'h0,	// Fifth-order sinc then averaging
		KIND_SINC5     = 2'h1,	// Plain fifth-order sinc
		KIND_SINC3     = 2'h2	// Not built, runs as sinc plus average
	} kind_type;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam kind_type    KIND_RST = KIND_SINC5_AVG;
	localparam logic [15:0] FS_RST   = 16'h0004;
	localparam logic [7:0]  REP_RST  = 8'h01;

	// ==========================================================
	// Decimation and timing counts, in divided-clock cycles
	// ==========================================================
	localparam int AVG_RATIO    = 128;	// Sinc stage ratio ahead of averaging
	localparam int SINC5_UNIT   = 32;	// Plain sinc ratio per setting step
	localparam int SINC5_ORDER  = 5;	// Output periods in a plain sinc settle
	localparam int SETTLE_PRE   = 4;	// Extra sinc periods before averaging
	localparam int FS5_MAX      = 256;	// Largest plain sinc setting
	localparam int PT_AVG_FS4   = 96;
	localparam int PT_AVG_OTHER = 98;
	localparam int PT5_FS1      = 98;
	localparam int PT5_FS2      = 114;
	localparam int PT5_OTHER    = 96;
	localparam int PT5_SEQ_LOW  = 64;
	localparam int PT_SEQ       = 0;

endpackage : sfd_pkg

/* sfd_sinc5.sv */
// Fifth-order sinc decimator with a run-time decimation ratio
module sfd_sinc5 #(
	parameter int W     = 66,	// Accumulator width, covers ratio 8192
	parameter int RAT_W = 14	// Width of the ratio input
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// Control
	input  wire logic             clr,
	input  wire logic             tick,
	input  wire logic [RAT_W-1:0] ratio,
	// Bitstream in, samples out
	input  wire logic             bit_in,
	output logic      [W-1:0]     out_data,
	output logic                  out_valid
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [4:0][W-1:0] integ;	// Integrator chain
		logic [4:0][W-1:0] dly;		// Comb delay taps
		logic [RAT_W-1:0]  cnt;		// Decimation phase
		logic [W-1:0]      data;	// Last sample
		logic              valid;	// Sample pulse
	} sinc_state_type;

	sinc_state_type q;
	sinc_state_type d;

	// Integrate every tick, comb once per ratio ticks
	always_comb begin
		logic [W-1:0] c;
		c = '0;
		d = q;
		d.valid = 1'b0;
		if (clr) begin
			// Channel change: wrap-around state is flushed
			d = '0;
		end else if (tick) begin
			d.integ[0] = q.integ[0] + W'(bit_in);
			for (int k = 1; k < 5; k++) begin
				d.integ[k] = q.integ[k] + q.integ[k-1];
			end
			if (q.cnt >= ratio - RAT_W'(1)) begin
				d.cnt = '0;
				c = q.integ[4];
				for (int k = 0; k < 5; k++) begin
					d.dly[k] = c;
					c = c - q.dly[k];
				end
				d.data = c;
				d.valid = 1'b1;
			end else begin
				d.cnt = q.cnt + RAT_W'(1);
			end
		end
	end

	// Register the state
	always_ff @(posedge mclk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign out_data  = q.data;
	assign out_valid = q.valid;

endmodule : sfd_sinc5

/* sfd_fifo.sv */
// Result FIFO with a registered head word
module sfd_fifo #(
	parameter int W     = 70,	// Word width
	parameter int DEPTH = 16	// Words, a power of two
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         reset,
	// Filling side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// Draining side
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);

	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;	// Storage
		logic [AW-1:0]           wp;	// Write pointer
		logic [AW-1:0]           rp;	// Read pointer
		logic [AW:0]             cnt;	// Words in storage
		logic [W-1:0]            head;	// Output word
		logic                    hv;	// Output word valid
	} fifo_state_type;

	fifo_state_type q;
	fifo_state_type d;

	// Write, then refill the head when it is free or taken
	always_comb begin
		logic wr;
		logic rd;
		wr = in_valid && (q.cnt != (AW+1)'(DEPTH));
		rd = (!q.hv || out_ready) && (q.cnt != '0);
		d = q;
		if (wr) begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + AW'(1);
		end
		if (rd) begin
			d.head = q.mem[q.rp];
			d.rp = q.rp + AW'(1);
			d.hv = 1'b1;
		end else if (out_ready) begin
			d.hv = 1'b0;
		end
		d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
	end

	// Register the state
	always_ff @(posedge mclk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Full shows only from the stored count, so it is honest
	assign in_ready  = q.cnt != (AW+1)'(DEPTH);
	assign out_valid = q.hv;
	assign out_data  = q.head;

endmodule : sfd_fifo

/* sfd_filter.sv */
// Sinc and averaging decimation filter with channel sequencer
// ==========================================================
// Summary of operation
// R01 - Filter kind input picks sinc variant
// R02 - FIR mode converts first enabled channel only
// R03 - Software avoids chopping together with FIR
// R04 - Reset default is sinc plus average
// R05 - Sinc stage fixed at ratio 128
// R06 - Averaging count is setting over four
// R07 - Setting four gives plain sinc rate
// R08 - Result every 128 times average cycles
// R09 - First result after (4+avg)*128 plus delay
// R10 - Delay 96 at setting four, else 98
// R11 - Channel change resets filter, full settle
// R12 - Aligned step: one or four intermediates
// R13 - Unaligned step: two or five intermediates
// R14 - Middle settings give tabled intermediate counts
// R15 - Several channels enabled run the sequencer
// R16 - Later sequenced channels settle without delay
// R17 - Repeats follow one output period apart
// R18 - Notches at clock/128 and over average
// R19 - Setting 50000 notches at ten hertz
// R20 - Plain sinc kind for high rates
// R21 - Plain sinc result every 32 times setting
// R22 - Low setting bits forced to zero
module sfd_filter #(
	parameter int CH_N   = 16,	// Channels
	parameter int SINC_W = 66,	// Sinc and result width
	parameter int DIV_W  = 8,	// Main clock divider width
	parameter int DEPTH  = 16	// Result FIFO depth
) (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      reset,
	// Modulator bitstream
	input  wire logic                      mod_bit,
	// Configuration, taken on cfg_load; main_clock_divider is used directly, not latched
	input  wire logic                      cfg_load,
	input  wire sfd_pkg::kind_type         filter_kind,
	input  wire logic                      fir_mode,
	input  wire logic [15:0]               decimation_setting,
	input  wire logic [CH_N-1:0]           chan_enable,
	input  wire logic [7:0]                chan_repeat,
	input  wire logic [DIV_W-1:0]          main_clock_divider,
	// Result stream
	output logic                           res_valid,
	output logic      [SINC_W-1:0]         res_data,
	output logic      [$clog2(CH_N)-1:0]   res_chan,
	input  wire logic                      res_ready,
	// Front end control and status
	output logic      [$clog2(CH_N)-1:0]   active_chan,
	output logic                           mod_reset,
	output logic                           settling,
	output logic                           overflow
);

	localparam int CH_W  = $clog2(CH_N);
	localparam int TMR_W = 22;	// Holds the longest settle
	localparam int RAT_W = 14;	// Holds 32 times 256

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,	// No channel enabled
		ST_LOAD = 3'h2,	// Start of a conversion run
		ST_CONV = 3'h4	// Converting
	} st_type;

	typedef struct packed {
		st_type            st;		// Sequencer state
		logic              mod_s1;	// Bitstream sync, first stage
		logic              mod_s2;	// Bitstream sync, second stage
		logic [DIV_W-1:0]  div_cnt;	// Clock divider phase
		logic              tick;	// Divided clock enable
		sfd_pkg::kind_type kind;	// Latched filter kind
		logic              fir;		// Latched FIR mode
		logic [15:0]       fs;		// Latched decimation setting
		logic [CH_N-1:0]   en;		// Latched channel enables
		logic [7:0]        rep;		// Latched repeat count
		logic [CH_W-1:0]   chan;	// Channel now converting
		logic [7:0]        rep_cnt;	// Results on this channel
		logic [TMR_W-1:0]  tmr;		// Ticks to next result
		logic [SINC_W-1:0] acc;		// Averaging sum
		logic [SINC_W-1:0] res;		// Result being pushed
		logic [CH_W-1:0]   res_ch;	// Its channel
		logic              push;	// FIFO write pulse
		logic              mod_rst;	// Filter reset pulse
		logic              settle;	// First result pending
		logic              ovf;		// Result lost on a full FIFO
	} sfd_state_type;

	sfd_state_type q;
	sfd_state_type d;

	// ==========================================================
	// Derived settings
	// ==========================================================
	logic [8:0]        fs5;			// Cleaned plain sinc setting
	logic [13:0]       avg;			// Averaging count
	logic              is5;			// Plain sinc kind
	logic [RAT_W-1:0]  ratio;		// Sinc decimation ratio
	logic [TMR_W-1:0]  period;		// Output data rate period
	logic [TMR_W-1:0]  base;		// Filter settling part
	logic [TMR_W-1:0]  pt_full;		// Delay after a manual change
	logic [TMR_W-1:0]  pt_seq;		// Delay inside a sequence
	logic              seq_on;		// Sequencer in use
	logic [SINC_W-1:0] s_data;		// Sinc sample
	logic              s_valid;		// Sinc sample pulse
	logic              fifo_ready;	// FIFO has room

	// R22 low bits cleared
	assign fs5 = (q.fs[8:0] == 9'h0) ? 9'h1 :
		(q.fs[8:0] > 9'(sfd_pkg::FS5_MAX)) ? 9'(sfd_pkg::FS5_MAX) :
		(q.fs[8:0] > 9'h2) ? {q.fs[8:2], 2'h0} : q.fs[8:0];

	// R06 count from setting
	// R07 one at four
	assign avg = (q.fs[15:2] == 14'h0) ? 14'h1 : q.fs[15:2];

	// R01 kind select
	// R20 plain sinc kind
	assign is5 = q.kind == sfd_pkg::KIND_SINC5;

	// R05 fixed sinc ratio
	// R21 plain sinc ratio
	assign ratio = is5 ? RAT_W'(fs5 * sfd_pkg::SINC5_UNIT) :
		RAT_W'(sfd_pkg::AVG_RATIO);

	// R08 output period
	assign period = is5 ? TMR_W'(fs5 * sfd_pkg::SINC5_UNIT) :
		TMR_W'(avg * sfd_pkg::AVG_RATIO);

	// R09 settle base
	assign base = is5 ?
		TMR_W'(fs5 * sfd_pkg::SINC5_UNIT * sfd_pkg::SINC5_ORDER) :
		TMR_W'((avg + sfd_pkg::SETTLE_PRE) * sfd_pkg::AVG_RATIO);

	// R10 processing delay
	always_comb begin
		if (is5) begin
			if (fs5 == 9'h1) begin
				pt_full = TMR_W'(sfd_pkg::PT5_FS1);
			end else if (fs5 == 9'h2) begin
				pt_full = TMR_W'(sfd_pkg::PT5_FS2);
			end else begin
				pt_full = TMR_W'(sfd_pkg::PT5_OTHER);
			end
		end else if (avg == 14'h1) begin
			pt_full = TMR_W'(sfd_pkg::PT_AVG_FS4);
		end else begin
			pt_full = TMR_W'(sfd_pkg::PT_AVG_OTHER);
		end
	end

	// R16 no delay in sequence, 64 for plain sinc at settings 1 and 2
	assign pt_seq = (is5 && fs5 <= 9'h2) ? TMR_W'(sfd_pkg::PT5_SEQ_LOW) :
		TMR_W'(sfd_pkg::PT_SEQ);

	// R15 sequencer when several enabled
	// R02 FIR keeps one channel
	assign seq_on = !q.fir && ($countones(q.en) > 1);

	// ==========================================================
	// Channel search
	// ==========================================================
	// First enabled channel after cur, wrapping round, or from channel 0 with from_top
	function automatic logic [CH_W-1:0] next_en(input logic [CH_N-1:0] en,
		input logic [CH_W-1:0] cur, input logic from_top);
		logic [CH_W-1:0] pick;
		logic            found;
		int              idx;
		pick = cur;
		found = 1'b0;
		for (int i = 0; i < CH_N; i++) begin
			idx = from_top ? i : (int'(cur) + 1 + i) % CH_N;
			if (!found && en[idx]) begin
				pick = CH_W'(idx);
				found = 1'b1;
			end
		end
		return pick;
	endfunction : next_en

	// ==========================================================
	// Sinc stage and result FIFO
	// ==========================================================
	// R18 sinc notch
	// R12 step response
	// R13 unaligned step
	// R14 middle settings
	sfd_sinc5 #(
		.W     (SINC_W),
		.RAT_W (RAT_W)
	) u_sinc (
		.mclk      (mclk),
		.reset     (reset),
		.clr       (q.mod_rst),
		.tick      (q.tick),
		.ratio     (ratio),
		.bit_in    (q.mod_s2),
		.out_data  (s_data),
		.out_valid (s_valid)
	);

	// Results queue here so a slow reader loses them only once the FIFO is full
	sfd_fifo #(
		.W     (SINC_W + CH_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.reset     (reset),
		.in_valid  (q.push),
		.in_data   ({q.res_ch, q.res}),
		.in_ready  (fifo_ready),
		.out_valid (res_valid),
		.out_data  ({res_chan, res_data}),
		.out_ready (res_ready)
	);

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		logic clr_win;
		logic last_rep;
		clr_win = 1'b0;
		last_rep = 1'b0;
		d = q;
		d.tick = 1'b0;
		d.push = 1'b0;
		d.mod_rst = 1'b0;

		// Bitstream comes from the front end, two stages
		d.mod_s1 = mod_bit;
		d.mod_s2 = q.mod_s1;

		// Divider: zero or one means every cycle
		if (main_clock_divider <= DIV_W'(1)) begin
			d.div_cnt = '0;
			d.tick = 1'b1;
		end else if (q.div_cnt >= main_clock_divider - DIV_W'(1)) begin
			d.div_cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.div_cnt = q.div_cnt + DIV_W'(1);
		end

		// R18 averaging window
		// R19 window sets notch
		// Window opens when one period is left before the result
		clr_win = q.tick && (q.st == ST_CONV) && (q.tmr == period);
		d.acc = (clr_win ? '0 : q.acc) + (s_valid ? s_data : '0);

		last_rep = (q.rep <= 8'h1) || (q.rep_cnt + 8'h1 >= q.rep);

		case (q.st)
			ST_IDLE: begin
				d.settle = 1'b0;
			end
			ST_LOAD: begin
				if (q.en == '0) begin
					d.st = ST_IDLE;
				end else begin
					// R11 reset and settle
					// R02 first enabled
					d.chan = next_en(q.en, q.chan, 1'b1);
					d.mod_rst = 1'b1;
					d.tmr = base + pt_full;
					d.rep_cnt = '0;
					d.settle = 1'b1;
					d.st = ST_CONV;
				end
			end
			ST_CONV: begin
				if (q.tick) begin
					d.tmr = q.tmr - TMR_W'(1);
					if (q.tmr <= TMR_W'(1)) begin
						d.res = d.acc;
						d.res_ch = q.chan;
						d.push = 1'b1;
						d.settle = 1'b0;
						if (seq_on && last_rep) begin
							// R15 next channel
							// R16 sequence settle
							d.chan = next_en(q.en, q.chan, 1'b0);
							d.mod_rst = 1'b1;
							d.rep_cnt = '0;
							d.tmr = base + pt_seq;
							d.settle = 1'b1;
						end else begin
							// R17 repeat spacing
							// R08 steady rate
							d.rep_cnt = q.rep_cnt + 8'h1;
							d.tmr = period;
						end
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// A new setup restarts the run with the full settle
		if (cfg_load) begin
			// R04 kind taken here
			d.kind = filter_kind;
			d.fir = fir_mode;
			d.fs = decimation_setting;
			d.en = chan_enable;
			d.rep = chan_repeat;
			d.st = ST_LOAD;
			d.ovf = 1'b0;
		end

		// Lost result, set wins over the clear
		if (q.push && !fifo_ready) begin
			d.ovf = 1'b1;
		end
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge mclk) begin
		if (reset) begin
			q <= '0;
			q.st <= ST_IDLE;
			// R04 default kind
			q.kind <= sfd_pkg::KIND_RST;
			q.fs <= sfd_pkg::FS_RST;
			q.rep <= sfd_pkg::REP_RST;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign active_chan = q.chan;
	assign mod_reset   = q.mod_rst;
	assign settling    = q.settle;
	assign overflow    = q.ovf;

endmodule : sfd_filter

/* sfd_filter_monitor.sv */
// Port checker of the sinc and averaging decimation filter
module sfd_filter_monitor #(
	parameter int CH_N   = 16,	// Channels
	parameter int SINC_W = 66,	// Result width
	parameter int DIV_W  = 8	// Divider width
) (
	// Clock and reset
	input wire logic                    mclk,
	input wire logic                    reset,
	// Configuration
	input wire logic                    cfg_load,
	input wire logic                    fir_mode,
	input wire logic [CH_N-1:0]         chan_enable,
	// Result stream
	input wire logic                    res_valid,
	input wire logic [SINC_W-1:0]       res_data,
	input wire logic [$clog2(CH_N)-1:0] res_chan,
	input wire logic                    res_ready,
	// Front end status
	input wire logic [$clog2(CH_N)-1:0] active_chan,
	input wire logic                    mod_reset,
	input wire logic                    settling,
	input wire logic                    overflow
);
	// ==========================================================
	// Helper count of cycles since the last restart
	// ==========================================================
	logic [15:0] settle_cnt_ff;	// Saturates so it never wraps to a small value
	logic [15:0] nxt_settle_cnt;

	// Restart clears the count
	always_comb begin
		nxt_settle_cnt = settle_cnt_ff;
		if (mod_reset) begin
			nxt_settle_cnt = 16'h0000;
		end else if (settle_cnt_ff != 16'hffff) begin
			nxt_settle_cnt = settle_cnt_ff + 16'h0001;
		end
	end

	// Register the count
	always_ff @(posedge mclk) begin
		settle_cnt_ff <= reset ? 16'h0000 : nxt_settle_cnt;
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_reset_quiet: assert property (disable iff (1'b0) reset |=>
		!res_valid && !settling && !overflow && !mod_reset) else $error("outputs busy after reset");
	a_load_restarts: assert property (cfg_load && chan_enable != '0 |-> ##2
		mod_reset && settling) else $error("load did not restart the filter");
	a_idle_no_start: assert property (cfg_load && chan_enable == '0 |-> ##2
		!mod_reset) else $error("restart with no channel enabled");
	a_restart_pulse: assert property (mod_reset |=> !mod_reset)
		else $error("restart pulse longer than one cycle");
	a_settle_on_restart: assert property (mod_reset |-> settling)
		else $error("restart without settling");
	a_settle_min: assert property ($fell(settling) && !$past(cfg_load) &&
		!$past(cfg_load, 2) |-> settle_cnt_ff >= 16'h00c8) else $error("settled too early");
	a_head_holds: assert property (res_valid && !res_ready |=> res_valid &&
		$stable(res_data) && $stable(res_chan)) else $error("result head changed while held");
	a_overflow_sticky: assert property (overflow && !cfg_load |=> overflow)
		else $error("overflow flag dropped");
	a_fir_single: assert property (fir_mode && !$past(cfg_load) &&
		!$past(cfg_load, 2) |-> !mod_reset) else $error("channel switch in FIR mode");
	a_chan_switch: assert property ($changed(active_chan) |-> mod_reset ||
		$past(cfg_load) || $past(cfg_load, 2)) else $error("channel moved without restart");

	// Main scenarios reached
	c_restart: cover property (mod_reset && settling);
	c_overflow: cover property (overflow && res_valid);
	c_fir_result: cover property (fir_mode && res_valid && res_ready);
endmodule : sfd_filter_monitor

bind sfd_filter sfd_filter_monitor #(.CH_N(CH_N), .SINC_W(SINC_W), .DIV_W(DIV_W))
	sfd_filter_monitor_inst (.mclk(mclk), .reset(reset), .cfg_load(cfg_load),
	.fir_mode(fir_mode), .chan_enable(chan_enable), .res_valid(res_valid),
	.res_data(res_data), .res_chan(res_chan), .res_ready(res_ready),
	.active_chan(active_chan), .mod_reset(mod_reset), .settling(settling),
	.overflow(overflow));

/* sfd_stream_model.sv */
// Far side model: modulator bitstream source and result consumer
module sfd_stream_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// Bench control
	input  wire logic        hold,
	input  wire logic        stall_rand,
	input  wire logic [31:0] rnd,
	// Modulator side
	input  wire logic        mod_reset,
	output logic             mod_bit,
	// Result side
	input  wire logic        res_valid,
	output logic             res_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [16:0] sum;	// Integrator plus input level, carry is the bit
	logic [15:0] integ;	// First order integrator

	assign sum = {1'b0, integ} + 17'h0a000;

	// no input swap chopping
	// Integrator restarts with the filter, so no stale state leaks across channels
	always @(posedge mclk) begin
		integ <= (reset || mod_reset) ? 16'h0000 : sum[15:0];
		mod_bit <= reset ? 1'b0 : sum[16];
		res_ready <= !reset && !hold && (!stall_rand || rnd[0]);
	end
endmodule : sfd_stream_model

/* tb_top.sv */
// Self-checking bench of the sinc and averaging decimation filter
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	// ==========================================================
	logic              mclk, reset, mod_bit, cfg_load, fir_mode, res_valid, res_ready;
	logic              mod_reset, settling, overflow, hold, stall_rand;
	sfd_pkg::kind_type filter_kind;
	logic [15:0]       decimation_setting, chan_enable;
	logic [7:0]        chan_repeat, main_clock_divider;
	logic [65:0]       res_data;
	logic [3:0]        res_chan, active_chan, ch;
	logic [31:0]       rnd;
	int                mismatches, checks, cycles, taken, dt, t0, i;

	sfd_filter #(.CH_N(16), .SINC_W(66), .DIV_W(8), .DEPTH(16)) sfd_filter_inst (
		.mclk(mclk), .reset(reset), .mod_bit(mod_bit), .cfg_load(cfg_load),
		.filter_kind(filter_kind), .fir_mode(fir_mode),
		.decimation_setting(decimation_setting), .chan_enable(chan_enable),
		.chan_repeat(chan_repeat), .main_clock_divider(main_clock_divider),
		.res_valid(res_valid), .res_data(res_data), .res_chan(res_chan),
		.res_ready(res_ready), .active_chan(active_chan), .mod_reset(mod_reset),
		.settling(settling), .overflow(overflow));
	sfd_stream_model sfd_stream_model_inst (.mclk(mclk), .reset(reset), .hold(hold),
		.stall_rand(stall_rand), .rnd(rnd), .mod_reset(mod_reset), .mod_bit(mod_bit),
		.res_valid(res_valid), .res_ready(res_ready));

	// ==========================================================
	// Clock, random source, taken count and hang guard
	// ==========================================================
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	always @(negedge mclk) begin
		rnd = lfsr(rnd);
	end
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (res_valid === 1'b1 && res_ready === 1'b1) taken = taken + 1;
		// Ceiling well above the roughly 17k cycles the tests need
		if (cycles == 60000) begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end

	// ==========================================================
	// Expectations
	// ==========================================================
	function automatic int avg_of(input int fs);
		// Low two bits are dropped, zero counts as one
		return (fs < 4) ? 1 : fs / 4;
	endfunction : avg_of
	function automatic int exp_period(input sfd_pkg::kind_type k, input int fs);
		return (k == sfd_pkg::KIND_SINC5) ? 32 * fs : 128 * avg_of(fs);
	endfunction : exp_period
	function automatic int exp_first(input sfd_pkg::kind_type k, input int fs, input bit seq);
		if (k == sfd_pkg::KIND_SINC5)
			return 160 * fs + (seq ? ((fs <= 2) ? 64 : 0) : ((fs == 1) ? 98 : (fs == 2) ? 114 : 96));
		return (4 + avg_of(fs)) * 128 + (seq ? 0 : ((avg_of(fs) == 1) ? 96 : 98));
	endfunction : exp_first
	// Pipeline from tick to visible head adds a few cycles
	function automatic logic [31:0] in_win(input int v, input int lo, input int span);
		return (v >= lo && v <= lo + span) ? 32'h1 : 32'h0;
	endfunction : in_win

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task automatic run_cfg(input sfd_pkg::kind_type k, input logic fir, input logic [15:0] fs,
		input logic [15:0] en, input logic [7:0] rep, input logic [7:0] div);
		filter_kind = k;
		fir_mode = fir;
		decimation_setting = fs;
		chan_enable = en;
		chan_repeat = rep;
		main_clock_divider = div;
		cfg_load = 1'b1;
		@(negedge mclk);
		cfg_load = 1'b0;
		@(negedge mclk);
		// Restart shows one cycle after the load is taken
		if (en != 16'h0000) begin
			chk("mod_reset", mod_reset, 32'h1);
			chk("settling", settling, 32'h1);
			chk("active_chan", active_chan, (en[0] ? 0 : en[1] ? 1 : 2));
		end
	endtask : run_cfg

	task automatic next_res();
		dt = 0;
		do begin
			@(negedge mclk);
			dt++;
		end while (res_valid !== 1'b1 && dt < 20000);
		ch = res_chan;
	endtask : next_res

	// One channel: first result after settling, then a fixed period
	task automatic single(input sfd_pkg::kind_type k, input int fs, input int div);
		int dv;
		dv = (div < 2) ? 1 : div;
		run_cfg(k, 1'b0, fs[15:0], 16'h0002, 8'h01, div[7:0]);
		next_res();
		chk("first", in_win(dt, exp_first(k, fs, 0) * dv - 2, 10 * dv), 32'h1);
		chk("chan", ch, 32'h1);
		repeat (2) begin
			next_res();
			chk("period", dt, exp_period(k, fs) * dv);
			// Settled sum: five eighths of the sinc ratio to the fifth, per sinc sample
			t0 = (k == sfd_pkg::KIND_SINC5) ? 5 * fs ** 5 : 5120 * avg_of(fs);
			if (dv == 1) chk("data", 32'(res_data >> 22), t0);
		end
	endtask : single

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{mismatches, checks, cycles, taken} = '0;
		{cfg_load, fir_mode, hold, stall_rand} = 4'h0;
		filter_kind = sfd_pkg::KIND_SINC5_AVG;
		decimation_setting = 16'h0004;
		chan_enable = 16'h0000;
		chan_repeat = 8'h01;
		main_clock_divider = 8'h01;
		rnd = 32'h6457;
		reset = 1'b1;
		repeat (12) @(negedge mclk);
		reset = 1'b0;
		@(negedge mclk);
		chk("rst_valid", res_valid, 32'h0);
		chk("rst_settling", settling, 32'h0);
		// Kinds, settings, divider and a random setting
		single(sfd_pkg::KIND_SINC5_AVG, 4, 1);
		single(sfd_pkg::KIND_SINC5_AVG, 8, 0);
		single(sfd_pkg::KIND_SINC5_AVG, 6, 1);
		single(sfd_pkg::KIND_SINC3, 8, 1);
		single(sfd_pkg::KIND_SINC5, 1, 1);
		single(sfd_pkg::KIND_SINC5, 2, 1);
		single(sfd_pkg::KIND_SINC5, 8, 1);
		single(sfd_pkg::KIND_SINC5_AVG, 4, 2);
		single(sfd_pkg::KIND_SINC5_AVG, 4 * (rnd % 3 + 1), 1);
		// Sequencer over channels 0 and 2, two results each
		run_cfg(sfd_pkg::KIND_SINC5_AVG, 1'b0, 16'h0004, 16'h0005, 8'h02, 8'h01);
		for (i = 0; i < 5; i++) begin
			next_res();
			chk("seq_chan", ch, ((i % 4) < 2) ? 0 : 2);
			if (i % 2 == 1) chk("seq_rep", dt, 128);
			if (i == 2 || i == 4) chk("seq_first", in_win(dt, 638, 12), 32'h1);
		end
		// FIR mode with two channels keeps the first
		run_cfg(sfd_pkg::KIND_SINC5_AVG, 1'b1, 16'h0004, 16'h000c, 8'h01, 8'h01);
		repeat (3) begin
			next_res();
			chk("fir_chan", ch, 32'h2);
		end
		// Fill with the consumer stalled, then drain with random stalls
		hold = 1'b1;
		run_cfg(sfd_pkg::KIND_SINC5, 1'b0, 16'h0001, 16'h0001, 8'h01, 8'h01);
		repeat (900) @(negedge mclk);
		chk("overflow", overflow, 32'h1);
		chk("held", res_valid, 32'h1);
		t0 = taken;
		hold = 1'b0;
		stall_rand = 1'b1;
		dt = 0;
		while (res_valid === 1'b1 && dt < 400) begin
			@(negedge mclk);
			dt++;
		end
		chk("drained", in_win(taken - t0, 17, 1 + dt / 32), 32'h1);
		// Load with nothing enabled: no restart, at most one result
		run_cfg(sfd_pkg::KIND_SINC5_AVG, 1'b0, 16'h0004, 16'h0000, 8'h01, 8'h01);
		chk("idle_restart", mod_reset, 32'h0);
		chk("ovf_clear", overflow, 32'h0);
		t0 = taken;
		repeat (1000) @(negedge mclk);
		chk("idle_results", in_win(taken - t0, 0, 1), 32'h1);
		give_verdict();
	end
endmodule : tb_top
